// *** core/ptl_pkg.sv ***
// Purpose: shared constants and types for the pattern test and loopback block
// Assumes: one clock, clk, at 20 MHz; synchronous active-low reset
// Notes:   widths fixed at documented values
package ptl_pkg;

  localparam logic [2:0]  TEST_SEL_PRBS    = 3'h4;
  localparam logic [19:0] T1_SEED          = 20'hFFFFF;
  localparam logic [14:0] E1_SEED          = 15'h7FFF;
  localparam int          T1_TAP_A         = 19;
  localparam int          T1_TAP_B         = 16;
  localparam int          E1_TAP_A         = 14;
  localparam int          E1_TAP_B         = 13;
  localparam logic [3:0]  ZERO_LIMIT       = 4'hE;
  localparam logic [6:0]  WINDOW_LAST      = 7'h7F;
  localparam logic [2:0]  LOCK_ERR_LIMIT   = 3'h4;
  localparam int          FIFO_WIDTH       = 2;
  localparam int          FIFO_DEPTH       = 16;

  typedef enum logic [2:0] {
    PTL_WRAP_NONE    = 3'h0,
    PTL_WRAP_ANALOG  = 3'h1,
    PTL_WRAP_REMOTE  = 3'h2,
    PTL_WRAP_DIGITAL = 3'h3,
    PTL_WRAP_DUAL    = 3'h4
  } ptl_wrap_t;

  typedef enum logic [1:0] {
    PTL_HUNT = 2'h0,
    PTL_LOCK = 2'h1
  } ptl_state_t;

  // dual-rail line symbol
  typedef struct packed {
    logic pos;
    logic neg;
  } ptl_rail_t;

endpackage : ptl_pkg

// *** core/ptl_fifo.sv ***
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
module ptl_fifo
  import ptl_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule : ptl_fifo

// *** core/ptl_top.sv ***
// Purpose: pattern generator/checker, error insertion and loopback routing
// Assumes: clk is the transmit line clock domain; line inputs are asynchronous
// Notes:   recovered receive data arrives as dual-rail, one symbol per clk
//
// How it works
// - generator and checker run only when transmit test select is 100
// - T1 mode: 2^20-1 sequence, runs of zeros capped at fourteen
// - E1 mode: 2^15-1 sequence with inverted output
// - lock after fewer than four errors in a 128-bit window
// - once locked, each bit error drops lock status low one cycle
// - with enable set, every lock status edge raises the interrupt
// - each rise of insert bit error flips one generated bit
// - each rise of insert violation inserts one bipolar violation in pattern test or single-rail mode
// - insertion controls sampled on clock edges, rises found from samples
// - hardware mode: two pins pick none, analog, remote, digital
// - host mode: top bit 0 means no loopback
// - analog wrap feeds transmit line output into receiver input
// - analog wrap ignores line inputs, still transmits to line
// - remote wrap, attenuator on receive: post-attenuator data to transmit
// - remote wrap ignores transmit inputs, keeps receive outputs
// - remote wrap, attenuator on transmit: recovered data through it
// - digital wrap routes transmit data through attenuator to receive out
// - digital wrap ignores line data, still transmits to line
// - dual wrap sends recovered data to line bypassing attenuator
// - dual wrap sends transmit data via attenuator to receive outputs
module ptl_top
  import ptl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       host_mode,
  input  wire logic [1:0] wrap_pins,
  input  wire logic [2:0] wrap_field,
  input  wire logic [2:0] transmit_test_select,
  input  wire logic       e1_mode,
  input  wire logic       single_rail,
  input  wire logic       atten_in_tx,
  input  wire logic       pattern_lock_irq_enable,
  input  wire logic       insert_bit_error,
  input  wire logic       insert_bipolar_violation,
  input  wire logic       tx_pos_in,
  input  wire logic       tx_neg_in,
  input  wire logic       rx_pos_line,
  input  wire logic       rx_neg_line,
  output logic            tx_line_positive,
  output logic            tx_line_negative,
  output logic            rx_positive_data_out,
  output logic            rx_negative_data_out,
  output logic            pattern_lock_status,
  output logic            irq,
  output logic            atten_full
);

  // input synchronisers
  logic [3:0] sync1_q, sync2_q;
  logic       ins_ber_q, ins_bpv_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {insert_bit_error, insert_bipolar_violation, rx_pos_line, rx_neg_line};
      sync2_q <= sync1_q;
    end
  end

  logic ber_s, bpv_s, ber_rise, bpv_rise;
  ptl_rail_t line_rx;
  assign ber_s        = sync2_q[3];
  assign bpv_s        = sync2_q[2];
  assign line_rx.pos  = sync2_q[1];
  assign line_rx.neg  = sync2_q[0];
  assign ber_rise     = ber_s && !ins_ber_q;
  assign bpv_rise     = bpv_s && !ins_bpv_q;

  // loopback decode
  function automatic ptl_wrap_t wrap_decode(input logic hm, input logic [1:0] p,
                                            input logic [2:0] f);
    if (!hm) begin
      wrap_decode = ptl_wrap_t'({1'b0, p});
    end else if (!f[2]) begin
      wrap_decode = PTL_WRAP_NONE;
    end else if (f[1:0] == 2'h0) begin
      wrap_decode = PTL_WRAP_DUAL;
    end else begin
      wrap_decode = ptl_wrap_t'({1'b0, f[1:0]});
    end
  endfunction : wrap_decode

  ptl_wrap_t wrap;
  logic      prbs_on;
  assign wrap    = wrap_decode(host_mode, wrap_pins, wrap_field);
  assign prbs_on = host_mode && (transmit_test_select == TEST_SEL_PRBS);

  // generator
  logic [19:0] gen_q, gen_d;
  logic [3:0]  gz_q, gz_d;
  logic        gen_bit, gen_raw;
  logic        bpv_pend_q, bpv_pend_d;
  always_comb begin
    gen_d = gen_q;
    gz_d  = gz_q;
    if (e1_mode) begin
      gen_raw = gen_q[E1_TAP_A] ^ gen_q[E1_TAP_B];
      gen_d   = {5'h00, gen_q[13:0], gen_raw};
      gen_bit = !gen_raw;
    end else begin
      gen_raw = gen_q[T1_TAP_A] ^ gen_q[T1_TAP_B];
      gen_d   = {gen_q[18:0], gen_raw};
      gen_bit = gen_raw;
      if (!gen_raw && gz_q == ZERO_LIMIT) begin
        gen_bit = 1'b1;
      end
      gz_d = gen_bit ? 4'h0 : gz_q + 4'h1;
    end
    if (!prbs_on) begin
      gen_d = e1_mode ? {5'h00, E1_SEED} : T1_SEED;
      gz_d  = 4'h0;
    end
  end

  // transmit symbol with insertions
  ptl_rail_t tx_src, tx_sym;
  logic      tx_mark, last_pol_q, last_pol_d, bpv_now;
  always_comb begin
    tx_mark = prbs_on ? (gen_bit ^ (ber_rise)) : tx_pos_in;
    bpv_now = bpv_pend_q && (prbs_on || single_rail);
    bpv_pend_d = bpv_pend_q || bpv_rise;
    last_pol_d = last_pol_q;
    if (prbs_on || single_rail) begin
      tx_src.pos = tx_mark && (bpv_now ? last_pol_q : !last_pol_q);
      tx_src.neg = tx_mark && (bpv_now ? !last_pol_q : last_pol_q);
      if (tx_mark && !bpv_now) begin
        last_pol_d = !last_pol_q;
      end
    end else begin
      tx_src.pos = tx_pos_in;
      tx_src.neg = tx_neg_in;
    end
    if (bpv_now && tx_mark) begin
      bpv_pend_d = bpv_rise;
    end
  end

  // jitter attenuator buffer
  ptl_rail_t att_in, att_out, line_sel;
  logic      att_valid, att_ready;
  always_comb begin
    if (wrap == PTL_WRAP_REMOTE && atten_in_tx) begin
      att_in = line_rx;
    end else if (wrap == PTL_WRAP_DIGITAL || wrap == PTL_WRAP_DUAL || atten_in_tx) begin
      att_in = tx_src;
    end else begin
      att_in = (wrap == PTL_WRAP_ANALOG) ? tx_sym : line_rx;
    end
  end

  ptl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_atten (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   (att_in),
    .in_valid  (1'b1),
    .in_ready  (att_ready),
    .out_data  (att_out),
    .out_valid (att_valid),
    .out_ready (1'b1)
  );
  assign atten_full = !att_ready;

  ptl_rail_t att_o;
  assign att_o = att_valid ? att_out : '0;

  // transmit and receive routing
  ptl_rail_t rx_sym;
  always_comb begin
    case (wrap)
      PTL_WRAP_REMOTE: begin
        tx_sym = att_o;
        rx_sym = atten_in_tx ? line_rx : att_o;
      end
      PTL_WRAP_DUAL: begin
        tx_sym = line_rx;
        rx_sym = att_o;
      end
      PTL_WRAP_DIGITAL: begin
        tx_sym = tx_src;
        rx_sym = att_o;
      end
      PTL_WRAP_ANALOG: begin
        tx_sym = atten_in_tx ? att_o : tx_src;
        rx_sym = atten_in_tx ? tx_sym : att_o;
      end
      default: begin
        tx_sym = atten_in_tx ? att_o : tx_src;
        rx_sym = atten_in_tx ? line_rx : att_o;
      end
    endcase
    line_sel = rx_sym;
  end

  // checker
  ptl_state_t  st_q, st_d;
  logic [19:0] chk_q, chk_d;
  logic [6:0]  win_q, win_d;
  logic [2:0]  err_q, err_d;
  logic [3:0]  cz_q, cz_d;
  logic        lock_q, lock_d, rx_bit, exp_bit, err, irq_q, irq_d, chk_raw, fb_bit;
  always_comb begin
    rx_bit  = line_sel.pos || line_sel.neg;
    chk_raw = e1_mode ? (chk_q[E1_TAP_A] ^ chk_q[E1_TAP_B])
                      : (chk_q[T1_TAP_A] ^ chk_q[T1_TAP_B]);
    // t1 expects a forced mark after a capped zero run
    exp_bit = e1_mode ? !chk_raw : (chk_raw || cz_q == ZERO_LIMIT);
    err     = rx_bit != exp_bit;
    // once locked the reference runs free, so one bad bit counts once
    fb_bit  = (st_q == PTL_LOCK) ? chk_raw : (rx_bit ^ e1_mode);
    chk_d   = e1_mode ? {5'h00, chk_q[13:0], fb_bit} : {chk_q[18:0], fb_bit};
    cz_d    = (e1_mode || ((st_q == PTL_LOCK) ? exp_bit : rx_bit)) ? 4'h0 : cz_q + 4'h1;
    st_d    = st_q;
    win_d   = win_q + 7'h1;
    err_d   = (err_q == LOCK_ERR_LIMIT) ? err_q : err_q + {2'h0, err};
    lock_d  = 1'b0;
    case (st_q)
      PTL_HUNT: begin
        if (win_q == WINDOW_LAST) begin
          if (err_d < LOCK_ERR_LIMIT) begin
            st_d = PTL_LOCK;
          end
          win_d = 7'h0;
          err_d = 3'h0;
        end
      end
      PTL_LOCK: begin
        lock_d = !err;
        win_d  = 7'h0;
        err_d  = 3'h0;
      end
      default: begin
        st_d = PTL_HUNT;
      end
    endcase
    if (!prbs_on) begin
      st_d   = PTL_HUNT;
      cz_d   = 4'h0;
      win_d  = 7'h0;
      err_d  = 3'h0;
      lock_d = 1'b0;
    end
    irq_d = pattern_lock_irq_enable && (lock_d != lock_q);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gen_q      <= T1_SEED;
      gz_q       <= 4'h0;
      ins_ber_q  <= 1'b0;
      ins_bpv_q  <= 1'b0;
      bpv_pend_q <= 1'b0;
      last_pol_q <= 1'b0;
      st_q       <= PTL_HUNT;
      chk_q      <= '0;
      cz_q       <= 4'h0;
      win_q      <= 7'h0;
      err_q      <= 3'h0;
      lock_q     <= 1'b0;
      irq_q      <= 1'b0;
      tx_line_positive     <= 1'b0;
      tx_line_negative     <= 1'b0;
      rx_positive_data_out <= 1'b0;
      rx_negative_data_out <= 1'b0;
    end else begin
      gen_q      <= gen_d;
      gz_q       <= gz_d;
      ins_ber_q  <= ber_s;
      ins_bpv_q  <= bpv_s;
      bpv_pend_q <= bpv_pend_d;
      last_pol_q <= last_pol_d;
      st_q       <= st_d;
      chk_q      <= chk_d;
      cz_q       <= cz_d;
      win_q      <= win_d;
      err_q      <= err_d;
      lock_q     <= lock_d;
      irq_q      <= irq_d;
      tx_line_positive     <= tx_sym.pos;
      tx_line_negative     <= tx_sym.neg;
      rx_positive_data_out <= rx_sym.pos;
      rx_negative_data_out <= rx_sym.neg;
    end
  end

  assign pattern_lock_status = lock_q;
  assign irq                 = irq_q;

endmodule : ptl_top

// *** tb/ptl_top_asserts.sv ***
// Purpose: port checks on the pattern test and loopback block
// Assumes: one clock, resetn synchronous active low
// Notes:   bound to every ptl_top
module ptl_top_asserts
  import ptl_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       host_mode,
  input wire logic [2:0] wrap_field,
  input wire logic [2:0] transmit_test_select,
  input wire logic       e1_mode,
  input wire logic       pattern_lock_irq_enable,
  input wire logic       tx_line_positive,
  input wire logic       tx_line_negative,
  input wire logic       rx_positive_data_out,
  input wire logic       rx_negative_data_out,
  input wire logic       pattern_lock_status,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic       tst, tst_q, t1_on, lk_q, lk_qq;
  logic [3:0] age_q, age_d;
  logic [4:0] zc_q, zc_d;
  assign tst   = host_mode && transmit_test_select == TEST_SEL_PRBS;
  assign t1_on = tst && !e1_mode && wrap_field == 3'h5;
  // settle, then count zero symbols on the line
  always_comb begin
    age_d = t1_on ? age_q + {3'h0, age_q != 4'h8} : 4'h0;
    zc_d  = (age_q == 4'h8 && !(tx_line_positive | tx_line_negative)) ? zc_q + 5'h1 : 5'h0;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {tst_q, lk_q, lk_qq, age_q, zc_q} <= '0;
    end else begin
      tst_q <= tst;
      lk_q  <= pattern_lock_status;
      lk_qq <= lk_q;
      age_q <= age_d;
      zc_q  <= zc_d;
    end
  end
  sequence s_back_high;
    ##1 pattern_lock_status;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !(tx_line_positive |
    tx_line_negative | rx_positive_data_out | rx_negative_data_out | pattern_lock_status | irq))
    else $error("outputs not cleared by reset");
  a_lock_test_only: assert property ($rose(pattern_lock_status) |-> tst_q)
    else $error("lock without pattern mode");
  a_off_unlocked: assert property (!tst [*8] |-> !pattern_lock_status)
    else $error("lock held with generator off");
  a_dip_one_cycle: assert property ($fell(pattern_lock_status) && tst && tst_q |-> s_back_high)
    else $error("lock dip longer than one cycle");
  a_irq_on_edge: assert property (pattern_lock_status != lk_q && pattern_lock_irq_enable |-> ##[0:1] irq)
    else $error("lock edge without irq");
  a_irq_has_cause: assert property (irq |-> lk_q != lk_qq || pattern_lock_status != lk_q)
    else $error("irq without lock edge");
  a_irq_needs_en: assert property (irq |-> pattern_lock_irq_enable || $past(pattern_lock_irq_enable))
    else $error("irq while disabled");
  a_zero_run_cap: assert property (zc_q <= 5'h0E)
    else $error("zero run too long");
endmodule : ptl_top_asserts

bind ptl_top ptl_top_asserts i_chk (
  .clk(clk), .resetn(resetn), .host_mode(host_mode), .wrap_field(wrap_field),
  .transmit_test_select(transmit_test_select), .e1_mode(e1_mode),
  .pattern_lock_irq_enable(pattern_lock_irq_enable),
  .tx_line_positive(tx_line_positive), .tx_line_negative(tx_line_negative),
  .rx_positive_data_out(rx_positive_data_out),
  .rx_negative_data_out(rx_negative_data_out),
  .pattern_lock_status(pattern_lock_status), .irq(irq));

// *** tb/ptl_line_model.sv ***
// Purpose: far-end line terminal sending recovered symbols
// Assumes: one symbol per clk, marks never on both rails while enabled
// Notes:   released line shows the inverse of its last value
module ptl_line_model (
  input  wire logic clk,
  input  wire logic en,
  output logic      pos,
  output logic      neg
);
  timeunit 1ns;
  timeprecision 1ns;
  int s = 99;
  int r;
  initial {pos, neg} = 2'h0;
  always @(posedge clk) begin
    r = $unsigned($random(s)) % 3;
    pos <= en ? (r == 1) : ~pos;
    neg <= en ? (r == 2) : ~neg;
  end
endmodule : ptl_line_model

// *** tb/ptl_top_tb.sv ***
// Purpose: self-checking bench for the pattern test and loopback block
// Assumes: 20 MHz clk, reset held four cycles
// Notes:   routes found by stream alignment, pattern by lock status
module ptl_top_tb import ptl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, resetn = 1'b0, host_mode = 1'b0, e1_mode = 1'b0;
  logic       single_rail = 1'b0, atten_in_tx = 1'b0, pattern_lock_irq_enable = 1'b0;
  logic       insert_bit_error = 1'b0, insert_bipolar_violation = 1'b0;
  logic       tx_pos_in = 1'b0, tx_neg_in = 1'b0, rx_pos_line, rx_neg_line;
  logic [1:0] wrap_pins = 2'h0;
  logic [2:0] wrap_field = 3'h0, transmit_test_select = 3'h0;
  logic       tx_line_positive, tx_line_negative, rx_positive_data_out;
  logic       rx_negative_data_out, pattern_lock_status, irq, atten_full;
  logic       far_en = 1'b0, drv = 1'b0, cap = 1'b0, lk1 = 1'b0, last_p = 1'b0;
  logic [1:0] qt[$], qr[$], qto[$], qro[$];
  int         err_total = 0, num_checks = 0, seed = 64, r, n_irq = 0, n_dip = 0, n_bpv = 0;
  localparam logic [6:0] CFG [11] = '{7'h01, 7'h08, 7'h13, 7'h17, 7'h18, 7'h59,
    7'h62, 7'h66, 7'h68, 7'h73, 7'h78};
  ptl_top i_dut (
    .clk(clk), .resetn(resetn), .host_mode(host_mode), .wrap_pins(wrap_pins),
    .wrap_field(wrap_field), .transmit_test_select(transmit_test_select),
    .e1_mode(e1_mode), .single_rail(single_rail), .atten_in_tx(atten_in_tx),
    .pattern_lock_irq_enable(pattern_lock_irq_enable), .insert_bit_error(insert_bit_error),
    .insert_bipolar_violation(insert_bipolar_violation), .tx_pos_in(tx_pos_in),
    .tx_neg_in(tx_neg_in), .rx_pos_line(rx_pos_line), .rx_neg_line(rx_neg_line),
    .tx_line_positive(tx_line_positive), .tx_line_negative(tx_line_negative),
    .rx_positive_data_out(rx_positive_data_out),
    .rx_negative_data_out(rx_negative_data_out),
    .pattern_lock_status(pattern_lock_status), .irq(irq), .atten_full(atten_full));
  ptl_line_model i_far (.clk(clk), .en(far_en), .pos(rx_pos_line), .neg(rx_neg_line));
  always #25 clk = ~clk;
  // framer stimulus and stream monitor
  always @(posedge clk) begin
    r = $unsigned($random(seed)) % 3;
    tx_pos_in <= drv && r == 1;
    tx_neg_in <= drv && r == 2;
    if (cap) begin
      qt.push_back({tx_pos_in, tx_neg_in});
      qr.push_back({rx_pos_line, rx_neg_line});
      qto.push_back({tx_line_positive, tx_line_negative});
      qro.push_back({rx_positive_data_out, rx_negative_data_out});
    end
    n_irq += int'(irq === 1'b1);
    n_dip += int'(lk1 === 1'b1 && pattern_lock_status === 1'b0);
    lk1 = pattern_lock_status;
    if ((tx_line_positive ^ tx_line_negative) === 1'b1) begin
      n_bpv += int'(tx_line_positive === last_p);
      last_p = tx_line_positive;
    end
  end
  task automatic chk(input string nm, input int exp, input int got);
    num_checks++;
    if (exp != got) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk
  // source stream must reappear on the output at one fixed offset
  function automatic int hit(input bit src_rx, input bit out_rx);
    for (int k = 1; k <= 48; k++) begin
      int ok;
      ok = 1;
      for (int i = 8; i < 40; i++)
        if ((out_rx ? qro[i + k] : qto[i + k]) !== (src_rx ? qr[i] : qt[i])) ok = 0;
      if (ok == 1) return 1;
    end
    return 0;
  endfunction : hit
  task automatic insert(input bit bpv, input int want_dip, input int want_irq);
    int a, b, v;
    a = n_dip;
    b = n_irq;
    v = n_bpv;
    insert_bit_error         <= 1'b0;
    insert_bipolar_violation <= 1'b0;
    @(posedge clk);
    insert_bit_error         <= !bpv;
    insert_bipolar_violation <= bpv;
    repeat (40) @(posedge clk);
    chk("violations", int'(bpv), n_bpv - v);
    if (!bpv) chk("lock_dips", want_dip, n_dip - a);
    if (!bpv) chk("irqs", want_irq, n_irq - b);
  endtask : insert
  task automatic prbs(input logic e1);
    int n;
    e1_mode <= e1;
    host_mode <= 1'b1;
    wrap_field <= 3'h5;
    transmit_test_select <= TEST_SEL_PRBS;
    pattern_lock_irq_enable <= 1'b1;
    n = 0;
    while (pattern_lock_status !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("locked", 1, int'(pattern_lock_status === 1'b1));
    chk("lock_wait", 1, int'(n >= 128));
    repeat (20) @(posedge clk);
    insert(1'b0, 1, 2);
    pattern_lock_irq_enable <= 1'b0;
    insert(1'b0, 1, 0);
    insert(1'b1, 0, 0);
    transmit_test_select <= 3'h0;
    repeat (20) @(posedge clk);
    chk("unlock", 0, int'(pattern_lock_status === 1'b1));
    $display("pattern test e1=%0d done", e1);
  endtask : prbs
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    #1_000_000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    drv <= 1'b1;
    far_en <= 1'b1;
    for (int c = 0; c < 11; c++) begin
      host_mode <= CFG[c][6];
      wrap_field <= CFG[c][5:3];
      wrap_pins <= CFG[c][4:3];
      atten_in_tx <= CFG[c][2];
      repeat (40) @(posedge clk);
      qt.delete();
      qr.delete();
      qto.delete();
      qro.delete();
      cap <= 1'b1;
      repeat (96) @(posedge clk);
      cap <= 1'b0;
      @(posedge clk);
      chk("tx_route", 1, hit(CFG[c][1], 1'b0));
      chk("rx_route", 1, hit(CFG[c][0], 1'b1));
      chk("atten_full", 0, int'(atten_full !== 1'b0));
      $display("route test %0d done", c);
    end
    prbs(1'b0);
    prbs(1'b1);
    wrap_field <= 3'h0;
    single_rail <= 1'b1;
    repeat (20) @(posedge clk);
    insert(1'b1, 0, 0);
    single_rail <= 1'b0;
    $display("single rail test done");
    host_mode <= 1'b0;
    wrap_pins <= 2'h1;
    transmit_test_select <= TEST_SEL_PRBS;
    repeat (400) @(posedge clk);
    chk("hw_lock", 0, int'(pattern_lock_status === 1'b1));
    $display("hardware mode test done");
    print_verdict();
  end
endmodule : ptl_top_tb
